// File: hw/aal_pkg.sv
// Shared constants and types for the adjust/add/logic decode block
package aal_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_OPCODE = 5'h04;
  localparam logic [4:0] OFS_OPA = 5'h08;
  localparam logic [4:0] OFS_OPB = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_RESULT = 5'h14;
  localparam logic [4:0] OFS_FLAGS = 5'h18;
  // Control bit positions
  localparam int CTL_PROT = 0;
  localparam int CTL_MISS = 1;
  localparam int CTL_TWO_REG = 2;
  localparam int CTL_MISALIGN = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status field positions
  localparam int STS_BUSY = 0;
  localparam int STS_INVALID = 1;
  localparam int STS_DEST_REG = 2;
  localparam int STS_OP_LSB = 4;
  localparam int STS_CYC_LSB = 8;
  // Flag bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_PARITY = 2;
  localparam int FLG_AUX = 4;
  localparam int FLG_ZERO = 6;
  localparam int FLG_SIGN = 7;
  localparam int FLG_OVER = 11;
  // Opcode encodings
  localparam logic [7:0] OPC_ASC_ADD = 8'h37;
  localparam logic [7:0] OPC_ASC_SUB = 8'h3F;
  localparam logic [7:0] OPC_ASC_MUL = 8'hD4;
  localparam logic [7:0] OPC_ASC_DIV = 8'hD5;
  localparam logic [7:0] OPC_BASE10 = 8'h0A;
  localparam logic [7:0] OPC_PRIV = 8'h63;
  localparam logic [5:0] OPC_IMM_GRP = 6'h20;
  localparam logic [4:0] GRP_ADD = 5'h00;
  localparam logic [4:0] GRP_ADC = 5'h02;
  localparam logic [4:0] GRP_AND = 5'h04;
  localparam logic [2:0] SEL_ADD = 3'h0;
  localparam logic [2:0] SEL_ADC = 3'h2;
  localparam logic [2:0] SEL_AND = 3'h4;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [1:0] FORM_IMM_ACC = 2'h2;
  // Decimal adjust constants
  localparam logic [3:0] ASC_DIGIT_MAX = 4'h9;
  localparam logic [7:0] ASC_FIX = 8'h06;
  localparam logic [7:0] ASC_LOW_NIB = 8'h0F;
  // Execution clock counts
  localparam logic [4:0] CYC_ASC = 5'h04;
  localparam logic [4:0] CYC_ASC_MUL = 5'h10;
  localparam logic [4:0] CYC_REG = 5'h01;
  localparam logic [4:0] CYC_HIT = 5'h03;
  localparam logic [4:0] CYC_MISS = 5'h05;
  localparam logic [4:0] CYC_PRIV_REG = 5'h06;
  localparam logic [4:0] CYC_PRIV_MEM = 5'h0A;
  localparam logic [4:0] CYC_PRIV_MISS = 5'h0A;
  localparam logic [4:0] CYC_TWO_REG = 5'h01;
  localparam logic [4:0] CYC_MIS_ONE = 5'h02;
  localparam logic [4:0] CYC_MIS_RMW = 5'h04;
  // Operation classes
  typedef enum logic [3:0] {
    OP_NONE, OP_ASC_ADD, OP_ASC_DIV, OP_ASC_MUL, OP_ASC_SUB,
    OP_ADD, OP_ADC, OP_AND, OP_PRIV
  } aal_op_t;
  typedef enum logic {ST_IDLE, ST_EXEC} aal_st_t;
  // Decoded instruction
  typedef struct packed {
    aal_op_t op;
    logic wide;
    logic dest_reg;
    logic mem;
    logic rmw;
    logic valid;
  } aal_dec_t;
  // Result word and flags
  typedef struct packed {
    logic [31:0] res;
    logic [15:0] flags;
  } aal_out_t;
  // Whole state of the main module
  typedef struct packed {
    aal_st_t st;
    logic busy;
    aal_dec_t dec;
    logic [3:0] ctrl;
    logic [15:0] ins;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] res;
    logic [15:0] flags;
    logic invalid;
    logic [4:0] last_cyc;
    logic wait_rq;
    logic [31:0] rdata;
  } aal_state_t;
  // State of the cycle timer
  typedef struct packed {
    logic [4:0] cnt;
  } aal_tmr_t;
endpackage

// File: hw/aal_timer.sv
// Execution clock counter
`timescale 1ns/1ps
module aal_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [4:0] load_val_i,
  output logic last_o
);
  aal_pkg::aal_tmr_t s_r;   // Registered state
  aal_pkg::aal_tmr_t s_nxt; // Next state

  // Load or count down to zero
  always_comb begin
    s_nxt = s_r;
    if (load_i) begin
      s_nxt.cnt = load_val_i;
    end else if (s_r.cnt != 5'h00) begin
      s_nxt.cnt = s_r.cnt - 5'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Final counted cycle
  assign last_o = (s_r.cnt == 5'h01);
endmodule

// File: hw/aal_alu.sv
// Result and flag evaluation for the decoded operations
`timescale 1ns/1ps
module aal_alu (
  input wire aal_pkg::aal_op_t op_i,
  input wire logic wide_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic [15:0] flags_i,
  output aal_pkg::aal_out_t out_o
);
  logic cin;            // Carry into the adder
  logic [32:0] sum_w;   // Full width sum
  logic [8:0] sum_b;    // Byte sum
  logic fix;            // Decimal adjust needed
  logic [7:0] ah_x10;   // High digit times ten
  logic [31:0] r;       // Result
  logic [15:0] f;       // Flags
  logic szp;            // Sign, zero, parity update

  assign cin = (op_i == aal_pkg::OP_ADC) & flags_i[aal_pkg::FLG_CARRY];
  assign sum_w = {1'b0, a_i} + {1'b0, b_i} + {32'h0, cin};
  assign sum_b = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]} + {8'h0, cin};
  assign fix = (a_i[3:0] > aal_pkg::ASC_DIGIT_MAX) | flags_i[aal_pkg::FLG_AUX];
  assign ah_x10 = 8'(a_i[15:8] * aal_pkg::OPC_BASE10);

  // Per operation result
  always_comb begin
    r = a_i;
    f = flags_i;
    szp = 1'b0;
    case (op_i)
      aal_pkg::OP_ADD, aal_pkg::OP_ADC: begin
        // Byte or full width by the w bit
        r = wide_i ? sum_w[31:0] : {a_i[31:8], sum_b[7:0]}; // RULE_17
        f[aal_pkg::FLG_CARRY] = wide_i ? sum_w[32] : sum_b[8];
        f[aal_pkg::FLG_OVER] = wide_i ?
          (a_i[31] == b_i[31]) && (r[31] != a_i[31]) :
          (a_i[7] == b_i[7]) && (r[7] != a_i[7]);
        f[aal_pkg::FLG_AUX] = a_i[4] ^ b_i[4] ^ r[4];
        szp = 1'b1;
      end
      aal_pkg::OP_AND: begin
        // Logic result, overflow and carry cleared, aux kept
        r = wide_i ? (a_i & b_i) : {a_i[31:8], a_i[7:0] & b_i[7:0]};
        f[aal_pkg::FLG_OVER] = 1'b0; // RULE_16
        f[aal_pkg::FLG_CARRY] = 1'b0; // RULE_16
        szp = 1'b1;
      end
      aal_pkg::OP_ASC_ADD, aal_pkg::OP_ASC_SUB: begin
        // Unpacked digit correction of the low byte
        if (fix) begin
          if (op_i == aal_pkg::OP_ASC_ADD) begin
            r[7:0] = a_i[7:0] + aal_pkg::ASC_FIX;
            r[15:8] = a_i[15:8] + 8'h01;
          end else begin
            r[7:0] = a_i[7:0] - aal_pkg::ASC_FIX;
            r[15:8] = a_i[15:8] - 8'h01;
          end
        end
        r[7:0] = r[7:0] & aal_pkg::ASC_LOW_NIB;
        f[aal_pkg::FLG_AUX] = fix;
        f[aal_pkg::FLG_CARRY] = fix;
      end
      aal_pkg::OP_ASC_MUL: begin
        // Split the low byte into two digits
        r[15:8] = a_i[7:0] / aal_pkg::OPC_BASE10;
        r[7:0] = a_i[7:0] % aal_pkg::OPC_BASE10;
        szp = 1'b1;
      end
      aal_pkg::OP_ASC_DIV: begin
        // Fold two digits into the low byte
        r[7:0] = ah_x10 + a_i[7:0];
        r[15:8] = 8'h00;
        szp = 1'b1;
      end
      aal_pkg::OP_PRIV: begin
        // Raise the selector's privilege field to the source's
        f[aal_pkg::FLG_ZERO] = a_i[1:0] < b_i[1:0];
        if (a_i[1:0] < b_i[1:0]) begin
          r[1:0] = b_i[1:0];
        end
      end
      default: begin
        r = a_i;
      end
    endcase
    if (szp) begin
      f[aal_pkg::FLG_SIGN] = wide_i ? r[31] : r[7]; // RULE_16
      f[aal_pkg::FLG_ZERO] = wide_i ? (r == 32'h0) : (r[7:0] == 8'h00); // RULE_16
      f[aal_pkg::FLG_PARITY] = ~^r[7:0]; // RULE_16
    end
  end

  assign out_o = {r, f};
endmodule

// File: hw/aal_decode.sv
// Decode, timing and register slave for the adjust/add/logic group
`timescale 1ns/1ps
// What this block does
// [RULE_01] 37 is adjust-after-add, 4 clocks
// [RULE_02] D5 0A is adjust-before-divide, 4 clocks
// [RULE_03] D4 0A is adjust-after-multiply, 16 clocks
// [RULE_04] 3F is adjust-after-subtract, 4 clocks
// [RULE_05] Register add-with-carry takes 1 clock
// [RULE_06] Immediate group 010: carry add, 1/3/5
// [RULE_07] Immediate group 000 selects add
// [RULE_08] Immediate group 100 selects AND
// [RULE_09] Register add takes 1 clock
// [RULE_10] Register AND takes 1 clock
// [RULE_11] Add to memory: 3 hit, 5 miss
// [RULE_12] Add from memory: 3 hit, 5 miss
// [RULE_13] 63 privilege adjust, protected only, 6/10/10
// [RULE_14] Two register address adds 1 clock
// [RULE_15] Misaligned adds 2, read-modify-write adds 4
// [RULE_16] AND clears overflow/carry, keeps aux
// [RULE_17] w picks width, d picks direction
module aal_decode (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic busy_o
);
  aal_pkg::aal_state_t s_r;   // Registered state
  aal_pkg::aal_state_t s_nxt; // Next state
  aal_pkg::aal_dec_t dec_c;   // Decode of the written opcode
  aal_pkg::aal_out_t alu_out; // Result of the running operation
  logic [4:0] cyc_c;          // Cycle count of the written opcode
  logic [4:0] cyc_x;          // Address penalty cycles
  logic [7:0] ins_b0;         // First opcode byte
  logic [7:0] ins_b1;         // Second byte
  logic mod_reg;              // Register operand form
  logic acc_wr;               // Write accepted this edge
  logic acc_op;               // Opcode write while idle
  logic tmr_last;             // Last execution cycle
  logic [31:0] sts_w;         // Status word
  logic [31:0] rd_mux;        // Read data selection

  assign ins_b0 = avs_writedata_i[7:0];
  assign ins_b1 = avs_writedata_i[15:8];
  assign mod_reg = (ins_b1[7:6] == aal_pkg::MOD_REG);
  assign acc_wr = avs_write_i & ~s_r.wait_rq;
  assign acc_op = acc_wr & (avs_address_i == aal_pkg::OFS_OPCODE) & ~s_r.busy;

  // Byte lane merge for register writes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    be_merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction

  // Opcode decode and base clock count
  always_comb begin
    dec_c = '0;
    cyc_c = 5'h00;
    cyc_x = 5'h00;
    if (ins_b0 == aal_pkg::OPC_ASC_ADD) begin
      dec_c.op = aal_pkg::OP_ASC_ADD; // RULE_01
      cyc_c = aal_pkg::CYC_ASC; // RULE_01
    end else if (ins_b0 == aal_pkg::OPC_ASC_SUB) begin
      dec_c.op = aal_pkg::OP_ASC_SUB; // RULE_04
      cyc_c = aal_pkg::CYC_ASC; // RULE_04
    end else if (ins_b0 == aal_pkg::OPC_ASC_DIV && ins_b1 == aal_pkg::OPC_BASE10) begin
      dec_c.op = aal_pkg::OP_ASC_DIV; // RULE_02
      cyc_c = aal_pkg::CYC_ASC; // RULE_02
    end else if (ins_b0 == aal_pkg::OPC_ASC_MUL && ins_b1 == aal_pkg::OPC_BASE10) begin
      dec_c.op = aal_pkg::OP_ASC_MUL; // RULE_03
      cyc_c = aal_pkg::CYC_ASC_MUL; // RULE_03
    end else if (ins_b0 == aal_pkg::OPC_PRIV && s_r.ctrl[aal_pkg::CTL_PROT]) begin
      // Selector operand, read-modify-write when in memory
      dec_c.op = aal_pkg::OP_PRIV; // RULE_13
      dec_c.wide = 1'b1;
      dec_c.mem = ~mod_reg;
      dec_c.rmw = ~mod_reg;
      cyc_c = mod_reg ? aal_pkg::CYC_PRIV_REG :
        (s_r.ctrl[aal_pkg::CTL_MISS] ? aal_pkg::CYC_PRIV_MISS : aal_pkg::CYC_PRIV_MEM); // RULE_13
    end else if (ins_b0[7:2] == aal_pkg::OPC_IMM_GRP) begin
      // Immediate group, operation chosen by the reg field
      case (ins_b1[5:3])
        aal_pkg::SEL_ADD: dec_c.op = aal_pkg::OP_ADD; // RULE_07
        aal_pkg::SEL_ADC: dec_c.op = aal_pkg::OP_ADC; // RULE_06
        aal_pkg::SEL_AND: dec_c.op = aal_pkg::OP_AND; // RULE_08
        default: dec_c.op = aal_pkg::OP_NONE;
      endcase
      dec_c.wide = ins_b0[0];
      dec_c.mem = ~mod_reg;
      dec_c.rmw = ~mod_reg;
      cyc_c = mod_reg ? aal_pkg::CYC_REG :
        (s_r.ctrl[aal_pkg::CTL_MISS] ? aal_pkg::CYC_MISS : aal_pkg::CYC_HIT); // RULE_06
    end else if (ins_b0[7:6] == 2'h0) begin
      // Register/memory forms of add, carry add and AND
      case (ins_b0[7:3])
        aal_pkg::GRP_ADD: dec_c.op = aal_pkg::OP_ADD; // RULE_09
        aal_pkg::GRP_ADC: dec_c.op = aal_pkg::OP_ADC; // RULE_05
        aal_pkg::GRP_AND: dec_c.op = aal_pkg::OP_AND; // RULE_10
        default: dec_c.op = aal_pkg::OP_NONE;
      endcase
      dec_c.wide = ins_b0[0]; // RULE_17
      if (ins_b0[2:1] == aal_pkg::FORM_IMM_ACC) begin
        // Immediate to accumulator
        dec_c.dest_reg = 1'b1;
        cyc_c = aal_pkg::CYC_REG;
      end else if (!ins_b0[2]) begin
        dec_c.dest_reg = ins_b0[1]; // RULE_17
        dec_c.mem = ~mod_reg;
        dec_c.rmw = ~mod_reg & ~ins_b0[1]; // RULE_11
        cyc_c = mod_reg ? aal_pkg::CYC_REG :
          (s_r.ctrl[aal_pkg::CTL_MISS] ? aal_pkg::CYC_MISS : aal_pkg::CYC_HIT); // RULE_12
      end else begin
        dec_c.op = aal_pkg::OP_NONE;
      end
    end
    dec_c.valid = (dec_c.op != aal_pkg::OP_NONE);
    // Address penalties on memory operands only
    if (dec_c.mem) begin
      if (s_r.ctrl[aal_pkg::CTL_TWO_REG]) begin
        cyc_x = aal_pkg::CYC_TWO_REG; // RULE_14
      end
      if (s_r.ctrl[aal_pkg::CTL_MISALIGN] && dec_c.wide) begin
        cyc_x = cyc_x + (dec_c.rmw ? aal_pkg::CYC_MIS_RMW : aal_pkg::CYC_MIS_ONE); // RULE_15
      end
    end
    cyc_c = cyc_c + cyc_x;
  end

  // Execution clock counter
  aal_timer u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(acc_op & dec_c.valid),
    .load_val_i(cyc_c),
    .last_o(tmr_last)
  );

  // Result evaluation
  aal_alu u_alu (
    .op_i(s_r.dec.op),
    .wide_i(s_r.dec.wide),
    .a_i(s_r.opa),
    .b_i(s_r.opb),
    .flags_i(s_r.flags),
    .out_o(alu_out)
  );

  // Status word assembly
  always_comb begin
    sts_w = 32'h0;
    sts_w[aal_pkg::STS_BUSY] = s_r.busy;
    sts_w[aal_pkg::STS_INVALID] = s_r.invalid;
    sts_w[aal_pkg::STS_DEST_REG] = s_r.dec.dest_reg;
    sts_w[aal_pkg::STS_OP_LSB +: 4] = s_r.dec.op;
    sts_w[aal_pkg::STS_CYC_LSB +: 5] = s_r.last_cyc;
  end

  // Read data selection, unmapped reads give zero
  always_comb begin
    case (avs_address_i)
      aal_pkg::OFS_CTRL: rd_mux = {28'h0, s_r.ctrl};
      aal_pkg::OFS_OPCODE: rd_mux = {16'h0, s_r.ins};
      aal_pkg::OFS_OPA: rd_mux = s_r.opa;
      aal_pkg::OFS_OPB: rd_mux = s_r.opb;
      aal_pkg::OFS_STATUS: rd_mux = sts_w;
      aal_pkg::OFS_RESULT: rd_mux = s_r.res;
      aal_pkg::OFS_FLAGS: rd_mux = {16'h0, s_r.flags};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus handshake, register writes and execution sequence
  always_comb begin
    s_nxt = s_r;
    // One wait cycle, then a one-cycle acknowledge
    s_nxt.wait_rq = ~((avs_read_i | avs_write_i) & s_r.wait_rq);
    if (avs_read_i & s_r.wait_rq) begin
      s_nxt.rdata = rd_mux;
    end
    // Operands, flags and control are frozen while running
    if (acc_wr && !s_r.busy) begin
      case (avs_address_i)
        // Only the low control bits exist, upper lanes are dropped
        aal_pkg::OFS_CTRL: s_nxt.ctrl = 4'(be_merge({28'h0, s_r.ctrl},
          avs_writedata_i, avs_byteenable_i));
        aal_pkg::OFS_OPA: s_nxt.opa = be_merge(s_r.opa, avs_writedata_i, avs_byteenable_i);
        aal_pkg::OFS_OPB: s_nxt.opb = be_merge(s_r.opb, avs_writedata_i, avs_byteenable_i);
        // Flags occupy the low half word only
        aal_pkg::OFS_FLAGS: s_nxt.flags = 16'(be_merge({16'h0, s_r.flags},
          avs_writedata_i, avs_byteenable_i));
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    case (s_r.st)
      aal_pkg::ST_IDLE: begin
        if (acc_op) begin
          s_nxt.ins = avs_writedata_i[15:0];
          s_nxt.invalid = ~dec_c.valid;
          if (dec_c.valid) begin
            s_nxt.dec = dec_c;
            s_nxt.last_cyc = cyc_c;
            s_nxt.busy = 1'b1;
            s_nxt.st = aal_pkg::ST_EXEC;
          end
        end
      end
      aal_pkg::ST_EXEC: begin
        // Commit on the last counted cycle
        if (tmr_last) begin
          s_nxt.res = alu_out.res;
          s_nxt.flags = alu_out.flags;
          s_nxt.busy = 1'b0;
          s_nxt.st = aal_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.busy = 1'b0;
        s_nxt.st = aal_pkg::ST_IDLE;
      end
    endcase
  end

  // State register, waitrequest high out of reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
      s_r.wait_rq <= 1'b1;
      s_r.ctrl <= aal_pkg::CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o = s_r.rdata;
  assign avs_waitrequest_o = s_r.wait_rq;
  assign busy_o = s_r.busy;

  // Length of the current busy run, checked when it ends
  logic [4:0] run_len;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_len <= 5'h00;
    end else begin
      run_len <= s_r.busy ? run_len + 5'h01 : 5'h00;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Busy runs of fixed length
  sequence s_run1;
    s_r.busy ##1 !s_r.busy;
  endsequence
  sequence s_run4;
    s_r.busy [*4] ##1 !s_r.busy;
  endsequence
  sequence s_run5;
    s_r.busy [*5] ##1 !s_r.busy;
  endsequence
  sequence s_run6;
    s_r.busy [*6] ##1 !s_r.busy;
  endsequence

  a_asc_add_time: assert property ( // RULE_01
    acc_op && ins_b0 == aal_pkg::OPC_ASC_ADD |=> s_run4)
    else $error("adjust after add not 4 clocks");
  a_asc_div_time: assert property ( // RULE_02
    acc_op && ins_b0 == aal_pkg::OPC_ASC_DIV && ins_b1 == aal_pkg::OPC_BASE10 |=> s_run4)
    else $error("adjust before divide not 4 clocks");
  a_asc_mul_time: assert property ( // RULE_03
    $fell(s_r.busy) && s_r.dec.op == aal_pkg::OP_ASC_MUL |-> run_len == 5'h10)
    else $error("adjust after multiply not 16 clocks");
  a_asc_sub_time: assert property ( // RULE_04
    acc_op && ins_b0 == aal_pkg::OPC_ASC_SUB |=> s_run4)
    else $error("adjust after subtract not 4 clocks");
  a_adc_reg_time: assert property ( // RULE_05
    acc_op && ins_b0[7:3] == aal_pkg::GRP_ADC && !ins_b0[2] && mod_reg |=> s_run1)
    else $error("register carry add not 1 clock");
  a_imm_adc_miss: assert property ( // RULE_06
    acc_op && ins_b0[7:2] == aal_pkg::OPC_IMM_GRP && ins_b1[5:3] == aal_pkg::SEL_ADC
    && !mod_reg && s_r.ctrl == 4'h2 |=> s_run5)
    else $error("immediate carry add miss not 5 clocks");
  a_imm_add_sel: assert property ( // RULE_07
    acc_op && ins_b0[7:2] == aal_pkg::OPC_IMM_GRP && ins_b1[5:3] == aal_pkg::SEL_ADD
    |=> s_r.busy && s_r.dec.op == aal_pkg::OP_ADD)
    else $error("immediate group 000 not add");
  a_imm_and_sel: assert property ( // RULE_08
    acc_op && ins_b0[7:2] == aal_pkg::OPC_IMM_GRP && ins_b1[5:3] == aal_pkg::SEL_AND
    |=> s_r.busy && s_r.dec.op == aal_pkg::OP_AND)
    else $error("immediate group 100 not AND");
  a_add_reg_time: assert property ( // RULE_09
    acc_op && ins_b0[7:3] == aal_pkg::GRP_ADD && !ins_b0[2] && mod_reg |=> s_run1)
    else $error("register add not 1 clock");
  a_and_reg_time: assert property ( // RULE_10
    acc_op && ins_b0[7:3] == aal_pkg::GRP_AND && !ins_b0[2] && mod_reg |=> s_run1)
    else $error("register AND not 1 clock");
  a_add_to_mem: assert property ( // RULE_11
    $fell(s_r.busy) && s_r.dec.op == aal_pkg::OP_ADD && s_r.dec.rmw && s_r.ctrl == 4'h0
    |-> run_len == 5'h03)
    else $error("add to memory hit not 3 clocks");
  a_add_from_mem: assert property ( // RULE_12
    acc_op && ins_b0[7:1] == 7'h01 && !mod_reg && s_r.ctrl == 4'h2 |=> s_run5)
    else $error("add from memory miss not 5 clocks");
  a_priv_reg_time: assert property ( // RULE_13
    acc_op && ins_b0 == aal_pkg::OPC_PRIV && mod_reg && s_r.ctrl[aal_pkg::CTL_PROT]
    |=> s_run6)
    else $error("privilege adjust register not 6 clocks");
  a_priv_real_bad: assert property ( // RULE_13
    acc_op && ins_b0 == aal_pkg::OPC_PRIV && !s_r.ctrl[aal_pkg::CTL_PROT]
    |=> s_r.invalid && !s_r.busy)
    else $error("privilege adjust accepted in real mode");
  a_two_reg_add: assert property ( // RULE_14
    $fell(s_r.busy) && s_r.dec.mem && s_r.dec.op != aal_pkg::OP_PRIV && s_r.ctrl == 4'h4
    |-> run_len == 5'h04)
    else $error("two register address penalty not 1 clock");
  a_misalign_rmw: assert property ( // RULE_15
    $fell(s_r.busy) && s_r.dec.rmw && s_r.dec.wide && s_r.dec.op != aal_pkg::OP_PRIV
    && s_r.ctrl == 4'h8 |-> run_len == 5'h07)
    else $error("misaligned read-modify-write penalty not 4");
  a_and_flags: assert property ( // RULE_16
    $fell(s_r.busy) && s_r.dec.op == aal_pkg::OP_AND |-> !s_r.flags[aal_pkg::FLG_OVER]
    && !s_r.flags[aal_pkg::FLG_CARRY]
    && s_r.flags[aal_pkg::FLG_AUX] == $past(s_r.flags[aal_pkg::FLG_AUX]))
    else $error("AND flags wrong");
  a_dir_width: assert property ( // RULE_17
    acc_op && ins_b0[7:6] == 2'h0 && ins_b0[5:3] == 3'h0 && !ins_b0[2]
    |=> s_r.dec.wide == $past(ins_b0[0]) && s_r.dec.dest_reg == $past(ins_b0[1]))
    else $error("w or d bit not honoured");
endmodule

// File: sim/testbench.sv
// Self-checking bench for the adjust/add/logic decode block
`timescale 1ns/1ps
module testbench;
  logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  int error_cnt = 0;
  int check_count = 0;
  // Device under test, all byte lanes enabled
  aal_decode i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      test_done();
    end
  endtask
  // Counts busy cycles until idle, bounded
  task automatic idle(output int k);
    k = 0;
    #1;
    while (busy_o === 1'b1 && k < 40) begin
      k++;
      @(posedge clk_i);
      #1;
    end
    // A run that never ends is a mismatch and stops the bench
    if (k >= 40) begin
      error_cnt++;
      $display("BAD busy_o expected 0 seen 1");
      test_done();
    end
  endtask
  // Issue one instruction and check its clock count
  task automatic run(input logic [3:0] c, input logic [15:0] ins, input int n);
    int k;
    bus(1'b1, aal_pkg::OFS_CTRL, {28'h0, c});
    bus(1'b1, aal_pkg::OFS_OPCODE, {16'h0, ins});
    idle(k);
    chk("busy cycles", 32'(n), 32'(k));
    bus(1'b0, aal_pkg::OFS_STATUS, 32'h0);
    chk("invalid", {31'h0, n == 0}, {31'h0, rd[aal_pkg::STS_INVALID]});
    // Cycle count field reports the accepted instruction's length
    if (n != 0) begin
      chk("cycle field", 32'(n), {27'h0, rd[aal_pkg::STS_CYC_LSB +: 5]});
    end
  endtask
  // All registers and unmapped space read zero after reset
  task automatic t_reset();
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      chk("reset value", 32'h0, rd);
    end
  endtask
  // Add result, flags, direction and width
  task automatic t_add();
    bus(1'b1, aal_pkg::OFS_OPA, 32'h80000001);
    bus(1'b1, aal_pkg::OFS_OPB, 32'h80000002);
    run(4'h0, 16'hC001, 1);
    bus(1'b0, aal_pkg::OFS_RESULT, 32'h0);
    chk("add result", 32'h00000003, rd);
    bus(1'b0, aal_pkg::OFS_FLAGS, 32'h0);
    chk("add flags", 32'h00000805, rd);
    bus(1'b0, aal_pkg::OFS_STATUS, 32'h0);
    chk("dest bit d0", 32'h0, {31'h0, rd[aal_pkg::STS_DEST_REG]});
    chk("op class", 32'h5, {28'h0, rd[7:4]});
    bus(1'b1, aal_pkg::OFS_OPA, 32'h000001FF);
    bus(1'b1, aal_pkg::OFS_OPB, 32'h00000001);
    run(4'h0, 16'hC002, 1);
    bus(1'b0, aal_pkg::OFS_STATUS, 32'h0);
    chk("dest bit d1", 32'h1, {31'h0, rd[aal_pkg::STS_DEST_REG]});
    bus(1'b0, aal_pkg::OFS_RESULT, 32'h0);
    chk("byte result", 32'h0, {24'h0, rd[7:0]});
    bus(1'b0, aal_pkg::OFS_FLAGS, 32'h0);
    chk("byte flags", 32'h00000055, rd);
  endtask
  // AND clears overflow and carry, keeps aux
  task automatic t_and();
    bus(1'b1, aal_pkg::OFS_FLAGS, 32'h00000811);
    bus(1'b1, aal_pkg::OFS_OPA, 32'h000000FF);
    bus(1'b1, aal_pkg::OFS_OPB, 32'h0000000F);
    run(4'h0, 16'hC021, 1);
    bus(1'b0, aal_pkg::OFS_RESULT, 32'h0);
    chk("and result", 32'h0000000F, rd);
    bus(1'b0, aal_pkg::OFS_FLAGS, 32'h0);
    chk("and flags", 32'h00000014, rd);
  endtask
  // Operand write while busy is ignored
  task automatic t_busy();
    int k;
    bus(1'b1, aal_pkg::OFS_OPA, 32'h00000005);
    bus(1'b1, aal_pkg::OFS_OPCODE, 32'h00000AD4);
    bus(1'b1, aal_pkg::OFS_OPA, 32'h00000009);
    bus(1'b0, aal_pkg::OFS_STATUS, 32'h0);
    chk("busy bit", 32'h1, {31'h0, rd[aal_pkg::STS_BUSY]});
    idle(k);
    bus(1'b0, aal_pkg::OFS_OPA, 32'h0);
    chk("opa kept", 32'h00000005, rd);
  endtask
  // Clock counts of every form
  task automatic t_timing();
    run(4'h0, 16'h0037, 4);
    run(4'h1, 16'h0037, 4);
    run(4'h0, 16'h0AD5, 4);
    run(4'h0, 16'h0AD4, 16);
    run(4'h1, 16'h003F, 4);
    run(4'h0, 16'hC011, 1);
    run(4'h0, 16'hD081, 1);
    run(4'h0, 16'h1081, 3);
    run(4'h2, 16'h1081, 5);
    run(4'h0, 16'hC081, 1);
    run(4'h0, 16'hE081, 1);
    run(4'h0, 16'hC881, 0);
    run(4'h0, 16'h0001, 3);
    run(4'h2, 16'h0001, 5);
    run(4'h0, 16'h0003, 3);
    run(4'h2, 16'h0003, 5);
    run(4'h1, 16'hC063, 6);
    run(4'h1, 16'h0063, 10);
    run(4'h3, 16'h0063, 10);
    run(4'h0, 16'hC063, 0);
    run(4'h4, 16'h0003, 4);
    run(4'h8, 16'h0003, 5);
    run(4'h8, 16'h0001, 7);
    run(4'h8, 16'h0005, 1);
  endtask
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_add();
    t_and();
    t_busy();
    t_timing();
    test_done();
  end
endmodule
